// ---- rtl/psc_top.sv ----
// Purpose: ahb-lite register front end for per-port statistics counters
// Assumes: single zero-wait writes, reads take one wait state
// Notes:   counters are reached only through trigger, index and value fields
`default_nettype none

// Behaviour
// RULE1 - thirty counters for each of ports one-seven
// RULE2 - per port control 0x500, data 0x504 only
// RULE3 - reading a counter clears it
// RULE4 - software writes trigger bit 25 to read
// RULE5 - trigger bit self-clears when value ready
// RULE6 - value bits 35:32 in control bits 3:0
// RULE7 - value bits 31:0 in data register
// RULE8 - bit 31 shows counter overflow
// RULE9 - bit 24 joins port to flush, freeze
// RULE10 - index bits 23:16 select the counter
// RULE11 - software polls trigger low before reading
module psc_top (
  input  wire logic                                     core_clk,
  input  wire logic                                     srst,
  input  wire logic                                     hsel,
  input  wire logic [psc_pkg::ADDR_W-1:0]               haddr,
  input  wire logic [1:0]                               htrans,
  input  wire logic                                     hwrite,
  input  wire logic [2:0]                               hsize,
  input  wire logic [psc_pkg::DATA_W-1:0]               hwdata,
  input  wire logic                                     hready,
  output logic [psc_pkg::DATA_W-1:0]                    hrdata,
  output logic                                          hreadyout,
  output logic                                          hresp,
  input  wire logic [psc_pkg::NUM_PORTS*psc_pkg::NUM_CNT-1:0] cnt_evt,
  output logic                                          irq
);
  import psc_pkg::*;

  // bus phase state
  logic [ADDR_W-1:0]       a_q;
  logic                    wr_pend_q;
  logic                    rd_wait_q;
  logic [DATA_W-1:0]       hrdata_q;
  logic                    accept;
  logic                    wr_commit;
  logic                    rd_capture;
  logic [DATA_W-1:0]       rd_mux;

  // global and interrupt registers
  logic                    freeze_q;
  logic                    flush_pulse;
  logic [INT_W-1:0]        sts_q;
  logic [INT_W-1:0]        mask_q;
  logic [INT_W-1:0]        sts_set;

  // per-port state
  logic                    trig_q   [NUM_PORTS];
  logic                    ffe_q    [NUM_PORTS];
  logic [IDX_W-1:0]        idx_q    [NUM_PORTS];
  logic [CNT_W-1:0]        value    [NUM_PORTS];
  logic                    ovf      [NUM_PORTS];
  logic [NUM_PORTS-1:0]    done_vec;
  logic [NUM_PORTS-1:0]    wrap_vec;

  assign accept     = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign wr_commit  = wr_pend_q;
  assign rd_capture = rd_wait_q;
  assign hreadyout  = !rd_wait_q;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_q;

  // address phase capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      a_q       <= '0;
      wr_pend_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      wr_pend_q <= accept && hwrite;
      rd_wait_q <= accept && !hwrite;
      if (accept) begin
        a_q <= haddr;
      end
    end
  end

  // read data, sampled after any earlier write has landed
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata_q <= RST_WORD;
    end else if (rd_capture) begin
      hrdata_q <= rd_mux;
    end
  end

  // read decode, unmapped reads return zero
  always_comb begin
    rd_mux = '0;
    case (a_q)
      ADDR_GLB_CTRL: rd_mux[GLB_FREEZE_BIT] = freeze_q;
      ADDR_INT_STS:  rd_mux[INT_W-1:0] = sts_q;
      ADDR_INT_MASK: rd_mux[INT_W-1:0] = mask_q;
      default:       rd_mux = '0;
    endcase
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (a_q == psc_port_addr(p, OFS_CTRL)) begin // RULE2
        rd_mux[CS_OVF_BIT]          = ovf[p]; // RULE8
        rd_mux[CS_TRIG_BIT]         = trig_q[p];
        rd_mux[CS_FFE_BIT]          = ffe_q[p];
        rd_mux[CS_IDX_LSB +: IDX_W] = idx_q[p];
        rd_mux[CS_HI_LSB +: HI_W]   = value[p][CNT_W-1 -: HI_W]; // RULE6
      end
      if (a_q == psc_port_addr(p, OFS_DATA)) begin // RULE2
        rd_mux = value[p][DATA_W-1:0]; // RULE7
      end
    end
  end

  // global control: flush is a write pulse, freeze a level
  assign flush_pulse = wr_commit && (a_q == ADDR_GLB_CTRL)
                       && hwdata[GLB_FLUSH_BIT];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      freeze_q <= 1'b0;
    end else if (wr_commit && (a_q == ADDR_GLB_CTRL)) begin
      freeze_q <= hwdata[GLB_FREEZE_BIT];
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mask_q <= RST_INT;
    end else if (wr_commit && (a_q == ADDR_INT_MASK)) begin
      mask_q <= hwdata[INT_W-1:0];
    end
  end

  // sticky status, read clears, a new event wins over the clear
  assign sts_set = {wrap_vec, done_vec};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sts_q <= RST_INT;
    end else if (rd_capture && (a_q == ADDR_INT_STS)) begin
      sts_q <= sts_set;
    end else begin
      sts_q <= sts_q | sts_set;
    end
  end

  assign irq = |(sts_q & mask_q);

  // one register pair and counter set per switch port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [ADDR_W-1:0] A_CTRL = psc_port_addr(p, OFS_CTRL);
    logic wr_ctrl;
    logic start;

    assign wr_ctrl = wr_commit && (a_q == A_CTRL); // RULE2
    assign start   = wr_ctrl && hwdata[CS_TRIG_BIT] && !trig_q[p]; // RULE4

    // trigger bit doubles as busy; cleared when the fetch lands
    always_ff @(posedge core_clk) begin
      if (srst) begin
        trig_q[p] <= 1'b0;
      end else if (start) begin
        trig_q[p] <= 1'b1;
      end else if (done_vec[p]) begin
        trig_q[p] <= 1'b0; // RULE5
      end
    end

    // enable and index are plain read/write fields
    always_ff @(posedge core_clk) begin
      if (srst) begin
        ffe_q[p] <= 1'b0;
        idx_q[p] <= '0;
      end else if (wr_ctrl) begin
        ffe_q[p] <= hwdata[CS_FFE_BIT]; // RULE9
        idx_q[p] <= hwdata[CS_IDX_LSB +: IDX_W]; // RULE10
      end
    end

    psc_port_counters u_cnt (
      .core_clk (core_clk),
      .srst     (srst),
      .cnt_evt  (cnt_evt[p*NUM_CNT +: NUM_CNT]), // RULE1
      .start    (start),
      .index    (hwdata[CS_IDX_LSB +: IDX_W]),
      .flush    (flush_pulse && ffe_q[p]), // RULE9
      .freeze   (freeze_q && ffe_q[p]), // RULE9
      .done     (done_vec[p]),
      .value_q  (value[p]),
      .ovf_q    (ovf[p]),
      .wrap     (wrap_vec[p])
    );
  end

endmodule : psc_top

`default_nettype wire

// ---- rtl/psc_pkg.sv ----
// Purpose: shared constants and types of the port statistics counter block
// Assumes: 32-bit ahb-lite register bus, one core clock
// Notes:   per-port registers sit at port number times 0x1000 plus offset
`default_nettype none

package psc_pkg;

  // array shape
  localparam int NUM_PORTS  = 7;
  localparam int FIRST_PORT = 1;
  localparam int NUM_CNT    = 30;
  localparam int CNT_W      = 36;
  localparam int IDX_W      = 8;
  localparam int HI_W       = 4;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 16;

  // address map
  localparam int                PORT_SHIFT    = 12;
  localparam logic [11:0]       OFS_CTRL      = 12'h500;
  localparam logic [11:0]       OFS_DATA      = 12'h504;
  localparam logic [ADDR_W-1:0] ADDR_GLB_CTRL = 16'h0300;
  localparam logic [ADDR_W-1:0] ADDR_INT_STS  = 16'h0310;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 16'h0314;

  // control and status fields
  localparam int CS_OVF_BIT  = 31;
  localparam int CS_TRIG_BIT = 25;
  localparam int CS_FFE_BIT  = 24;
  localparam int CS_IDX_LSB  = 16;
  localparam int CS_HI_LSB   = 0;

  // global control fields
  localparam int GLB_FLUSH_BIT  = 0;
  localparam int GLB_FREEZE_BIT = 1;

  // interrupt status layout
  localparam int INT_W        = 14;
  localparam int INT_DONE_LSB = 0;
  localparam int INT_WRAP_LSB = 7;

  // ahb-lite
  localparam int HTRANS_ACT_BIT = 1;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [INT_W-1:0]  RST_INT  = 14'h0000;

  typedef enum logic {RD_IDLE, RD_FETCH} psc_rd_state_type;

  function automatic logic [ADDR_W-1:0] psc_port_addr(input int p,
                                                      input logic [11:0] ofs);
    logic [3:0] num;
    num = 4'(p + FIRST_PORT);
    return {num, ofs};
  endfunction : psc_port_addr

endpackage : psc_pkg

`default_nettype wire

// ---- rtl/psc_port_counters.sv ----
// Purpose: one switch port's set of statistics counters with read-clear
// Assumes: count events are one-cycle pulses on core_clk
// Notes:   a fetch takes one cycle after start and pulses done
`default_nettype none

module psc_port_counters (
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  input  wire logic [psc_pkg::NUM_CNT-1:0]     cnt_evt,
  input  wire logic                            start,
  input  wire logic [psc_pkg::IDX_W-1:0]       index,
  input  wire logic                            flush,
  input  wire logic                            freeze,
  output logic                                 done,
  output logic [psc_pkg::CNT_W-1:0]            value_q,
  output logic                                 ovf_q,
  output logic                                 wrap
);
  import psc_pkg::*;

  psc_rd_state_type       state_q;
  logic [IDX_W-1:0]       idx_q;
  logic [CNT_W-1:0]       cnt_q [NUM_CNT];
  logic [NUM_CNT-1:0]     ovf_flag_q;
  logic [NUM_CNT-1:0]     wrap_vec;
  logic                   idx_ok;

  assign idx_ok = idx_q < IDX_W'(NUM_CNT);
  assign done   = (state_q == RD_FETCH);
  assign wrap   = |wrap_vec;

  // fetch sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= RD_IDLE;
      idx_q   <= '0;
    end else begin
      case (state_q)
        RD_IDLE: begin
          if (start) begin
            state_q <= RD_FETCH;
            idx_q   <= index; // RULE10
          end
        end
        RD_FETCH: state_q <= RD_IDLE;
        default:  state_q <= RD_IDLE;
      endcase
    end
  end

  // value capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      value_q <= '0;
      ovf_q   <= 1'b0;
    end else if (done) begin
      value_q <= idx_ok ? cnt_q[idx_q[4:0]] : '0;
      ovf_q   <= idx_ok ? ovf_flag_q[idx_q[4:0]] : 1'b0; // RULE8
    end
  end

  // counter array
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    logic inc_ok;
    logic clr;
    assign inc_ok      = cnt_evt[i] && !freeze; // RULE9
    assign clr         = done && (idx_q == IDX_W'(i));
    assign wrap_vec[i] = inc_ok && (&cnt_q[i]);

    always_ff @(posedge core_clk) begin
      if (srst || flush) begin // RULE9
        cnt_q[i] <= '0;
      end else if (clr) begin
        cnt_q[i] <= inc_ok ? CNT_W'(1) : '0; // RULE3
      end else if (inc_ok) begin
        cnt_q[i] <= cnt_q[i] + CNT_W'(1); // RULE1
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst || flush) begin
        ovf_flag_q[i] <= 1'b0;
      end else if (wrap_vec[i]) begin
        ovf_flag_q[i] <= 1'b1; // RULE8
      end else if (clr) begin
        ovf_flag_q[i] <= 1'b0;
      end
    end
  end

endmodule : psc_port_counters

`default_nettype wire

// ---- dv/psc_top_chk.sv ----
// Purpose: bus and interrupt timing checks on the counter readout block
// Assumes: one slave, hready tied to hreadyout
// Notes:   bound to every psc_top instance
`default_nettype none

module psc_top_chk (
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic                       hsel,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [psc_pkg::DATA_W-1:0] hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic                       irq
);
  logic rd_take;
  logic wr_take;
  logic wr_seen_q;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // no mask can be set before the first write
  always_ff @(posedge core_clk) begin
    if (srst) wr_seen_q <= 1'b0;
    else if (wr_take) wr_seen_q <= 1'b1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_one_wait: assert property (
    rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  a_stall_cause: assert property (!hreadyout |-> $past(rd_take))
    else $error("stall without read");
  a_stall_short: assert property (!hreadyout |=> hreadyout)
    else $error("stall too long");
  a_rdata_holds: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_irq_masked: assert property (!wr_seen_q |-> !irq)
    else $error("irq with mask clear");
  a_reset_quiet: assert property (disable iff (1'b0)
    srst |=> hreadyout && !irq && hrdata == '0)
    else $error("outputs not at reset values");
endmodule : psc_top_chk

bind psc_top psc_top_chk psc_top_chk_i (.core_clk(core_clk), .srst(srst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

`default_nettype wire

// ---- dv/psc_top_tb.sv ----
// Purpose: self-checking bench for the counter readout block
// Assumes: ahb-lite master in the bench, hready from hreadyout
// Notes:   counts kept small, no overflow run
`default_nettype none

module psc_top_tb;
  import psc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         core_clk, srst, hsel, hwrite;
  logic [ADDR_W-1:0]            haddr;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic [DATA_W-1:0]            hwdata, hrdata, d;
  logic                         hreadyout, hresp, irq;
  logic [NUM_PORTS*NUM_CNT-1:0] cnt_evt;
  wire logic                    hready;
  int                           err_total, compares, cyc;
  assign hready = hreadyout;
  psc_top psc_top_i (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cnt_evt(cnt_evt), .irq(irq));
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  function automatic logic [15:0] adr(input int p, input logic [11:0] o);
    return {4'(p), o};
  endfunction : adr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : wait_rdy
  task automatic xfer(input logic [15:0] a, input logic w,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    d = hrdata;
  endtask : xfer
  task automatic pulse(input int p, input int i, input int n);
    cnt_evt[(p-1)*NUM_CNT+i] <= 1'b1;
    repeat (n) @(posedge core_clk);
    cnt_evt <= '0;
    @(posedge core_clk);
  endtask : pulse
  task automatic fetch(input int p, input int i, input logic f,
                       input logic [35:0] e);
    int n;
    xfer(adr(p, OFS_CTRL), 1'b1, {6'h0, 1'b1, f, 8'(i), 16'h0});
    n = 0;
    d = 32'h0200_0000;
    while (d[25] === 1'b1 && n < 20) begin
      xfer(adr(p, OFS_CTRL), 1'b0, 32'h0);
      n++;
    end
    chk(d, {7'h0, f, 8'(i), 12'h0, e[35:32]});
    xfer(adr(p, OFS_DATA), 1'b0, 32'h0);
    chk(d, e[31:0]);
  endtask : fetch
  task automatic t_reset;
    xfer(adr(1, OFS_CTRL), 1'b0, 32'h0);
    chk(d, 32'h0);
    xfer(16'h0500, 1'b1, 32'hffff_ffff);
    xfer(16'h0500, 1'b0, 32'h0);
    chk(d, 32'h0);
    xfer(adr(7, OFS_DATA), 1'b0, 32'h0);
    chk(d, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_counts;
    for (int p = 1; p <= 7; p++) begin
      pulse(p, 30 - p, p + 2);
      fetch(p, 30 - p, 1'b0, 36'(p + 2));
      fetch(p, 30 - p, 1'b0, 36'h0);
    end
    pulse(1, 0, 3);
    fetch(1, 30, 1'b0, 36'h0);
    fetch(1, 0, 1'b0, 36'h3);
    $display("test counts done");
  endtask : t_counts
  task automatic t_flush;
    xfer(adr(2, OFS_CTRL), 1'b1, 32'h0100_0000);
    pulse(2, 1, 4);
    pulse(3, 1, 4);
    xfer(ADDR_GLB_CTRL, 1'b1, 32'h1);
    fetch(2, 1, 1'b1, 36'h0);
    fetch(3, 1, 1'b0, 36'h4);
    xfer(ADDR_GLB_CTRL, 1'b1, 32'h2);
    pulse(2, 1, 4);
    pulse(3, 1, 5);
    xfer(ADDR_GLB_CTRL, 1'b1, 32'h0);
    fetch(2, 1, 1'b1, 36'h0);
    fetch(3, 1, 1'b0, 36'h5);
    $display("test flush done");
  endtask : t_flush
  task automatic t_irq;
    xfer(ADDR_INT_STS, 1'b0, 32'h0);
    xfer(ADDR_INT_MASK, 1'b1, 32'h1);
    fetch(4, 0, 1'b0, 36'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(ADDR_INT_STS, 1'b0, 32'h0);
    chk(d, 32'h8);
    fetch(1, 0, 1'b0, 36'h0);
    chk({31'h0, irq}, 32'h1);
    xfer(ADDR_INT_STS, 1'b0, 32'h0);
    chk(d, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask : t_irq
  task automatic give_verdict;
    $display("compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {core_clk, hsel, hwrite, htrans, haddr, hwdata} = '0;
    srst = 1'b1;
    hsize = 3'h2;
    cnt_evt = '0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_reset;
    t_counts;
    t_flush;
    t_irq;
    give_verdict();
  end
endmodule : psc_top_tb

`default_nettype wire
